// [hw/store_arith_trap_exec.sv]
// Execution slice: word stores, subtracts, add-constant, leading zeros, supervisor traps
//
// Operation
// - Select bit zero picks a global register, one picks a local one.
// - Post-increment store writes source at local address, then adds 4 always.
// - Register-address store writes source at local address, address unchanged.
// - Stack store writes at destination, then adds signed displacement unless destination is global PC or SR.
// - Displacement: 20 sign copies plus field, or 4 copies plus two fields.
// - Subtract puts destination minus source in destination, updates flags.
// - Status word as subtract source means carry flag is subtracted.
// - Subtract with borrow removes source plus carry, writes and flags.
// - Checked forms are signed; overflow raises range error after writeback.
// - Constant: 18 sign copies plus field, or 2 copies plus two fields.
// - Add-constant writes source plus constant; status source means carry.
// - Add-constant sets zero, negative from bit 31, overflow on signed overflow.
// - Leading zero count of local source into local destination, flags kept.
// - Trap entry is 24 ones, address byte bits 7..2, two zeros.
// - Taken trap loads entry and sets supervisor; else continue sequentially.
// - Return address with old supervisor at frame+length; old status next.
// - Saved status carries instruction length code one.
// - Frame advances by old length, length six, clear M and T, set L.
// - Trap code is opcode bits 9..8 with address bits 1..0; 0..3 branch.
// - Codes 4..14 trap on flag conditions, code 15 always.
// - Trap number selects one of 64 entries.
`timescale 1ns/1ps
`include "core_exec_regs.svh"
module store_arith_trap_exec (
   input  wire logic               clk_i,
   input  wire logic               reset_i,
   input  wire logic               op_valid_i,
   input  wire core_exec_pkg::op_t op_i,
   input  wire logic               src_local_i,
   input  wire logic [3:0]         src_code_i,
   input  wire logic               dst_local_i,
   input  wire logic [3:0]         dst_code_i,
   input  wire logic               imm_sign_i,
   input  wire logic               imm_ext_i,
   input  wire logic [13:0]        imm1_i,
   input  wire logic [15:0]        imm2_i,
   input  wire logic [1:0]         trap_op_i,
   input  wire logic [7:0]         adr_byte_i,
   input  wire logic [31:0]        next_pc_i,
   input  wire logic               load_valid_i,
   input  wire logic               load_local_i,
   input  wire logic [3:0]         load_code_i,
   input  wire logic [31:0]        load_data_i,
   input  wire logic               obs_local_i,
   input  wire logic [3:0]         obs_code_i,
   output logic      [31:0]        obs_data_o,
   output logic      [31:0]        pc_o,
   output logic      [31:0]        sr_o,
   output logic                    mem_we_o,
   output logic      [31:0]        mem_addr_o,
   output logic      [31:0]        mem_wdata_o,
   output logic                    done_o,
   output logic                    range_error_o,
   output logic                    trap_taken_o,
   output logic                    branch_op_o
);
   import core_exec_pkg::*;

   // ============================================================
   // Register state
   logic [31:0] glob_q [15:2];
   logic [31:0] loc_q  [0:63];
   logic [31:0] pc_q;
   logic [31:0] sr_q;
   logic [31:0] sr_d;
   logic [31:0] mem_addr_q;
   logic [31:0] mem_wdata_q;
   logic [31:0] obs_q;
   logic        mem_we_q;
   logic        done_q;
   logic        range_q;
   logic        trap_q;
   logic        branch_q;
   logic [5:0]  ld_idx_q;

   // Locals live in a 64-entry ring addressed relative to the frame pointer
   wire [5:0] fp_lo = sr_q[`SR_FP_LSB +: 6];
   wire [3:0] fl    = sr_q[`SR_FL_LSB +: 4];
   wire       c_in  = sr_q[`SR_C];

   function automatic logic [31:0] rd_reg(input logic loc, input logic [3:0] code);
      logic [5:0] idx;
      idx = fp_lo + {2'b00, code};
      if (loc)
         rd_reg = loc_q[idx];
      else if (code == `REG_PC)
         rd_reg = pc_q;
      else if (code == `REG_SR)
         rd_reg = sr_q;
      else
         rd_reg = glob_q[code];
   endfunction

   // ============================================================
   // Operand decode
   wire [31:0] src_val    = rd_reg(src_local_i, src_code_i);
   wire [31:0] dst_val    = rd_reg(dst_local_i, dst_code_i);
   wire [31:0] ld_val     = rd_reg(1'b1, dst_code_i);
   wire [31:0] ls_val     = rd_reg(1'b1, src_code_i);
   wire [5:0]  dst_idx    = fp_lo + {2'b00, dst_code_i};
   wire        src_is_sr  = !src_local_i && (src_code_i == `REG_SR);
   wire [31:0] opnd_src   = src_is_sr ? {31'h0000_0000, c_in} : src_val;

   wire [31:0] dis_short  = {{20{imm_sign_i}}, imm1_i[11:0]};
   wire [31:0] dis_long   = {{4{imm_sign_i}}, imm1_i[11:0], imm2_i};
   wire [31:0] dis        = imm_ext_i ? dis_long : dis_short;
   wire [31:0] cst_short  = {{18{imm_sign_i}}, imm1_i};
   wire [31:0] cst_long   = {{2{imm_sign_i}}, imm1_i, imm2_i};
   wire [31:0] cst        = imm_ext_i ? cst_long : cst_short;

   wire is_sum    = (op_i == OP_SUM) || (op_i == OP_SUM_CHECKED);
   wire is_sub    = (op_i == OP_SUB) || (op_i == OP_SUB_BORROW) || (op_i == OP_SUB_CHECKED);
   wire is_check  = (op_i == OP_SUB_CHECKED) || (op_i == OP_SUM_CHECKED);
   wire [31:0] alu_a   = is_sum ? opnd_src : dst_val;
   wire [31:0] alu_b   = is_sum ? cst : opnd_src;
   wire        alu_cin = (op_i == OP_SUB_BORROW) && c_in;
   wire [31:0] alu_sum;
   wire        alu_z;
   wire        alu_n;
   wire        alu_v;
   wire        alu_c;

   add_flags_unit u_alu (
      .a_i   (alu_a),
      .b_i   (alu_b),
      .sub_i (!is_sum),
      .cin_i (alu_cin),
      .sum_o (alu_sum),
      .z_o   (alu_z),
      .n_o   (alu_n),
      .v_o   (alu_v),
      .c_o   (alu_c)
   );

   wire [5:0] lz_count;

   lead_zero_count u_lzc (
      .value_i (ls_val),
      .count_o (lz_count)
   );

   // ============================================================
   // Trap decode
   wire [3:0] trap_code = {trap_op_i, adr_byte_i[1:0]};
   wire       fz = sr_q[`SR_Z];
   wire       fn = sr_q[`SR_N];
   wire       fv = sr_q[`SR_V];
   logic      trap_cond;

   always_comb begin
      case (trap_code[3:0])
         4'h4:    trap_cond = fn || fz;
         4'h5:    trap_cond = !fn && !fz;
         4'h6:    trap_cond = fn;
         4'h7:    trap_cond = !fn;
         4'h8:    trap_cond = c_in || fz;
         4'h9:    trap_cond = !c_in && !fz;
         4'hA:    trap_cond = c_in;
         4'hB:    trap_cond = !c_in;
         4'hC:    trap_cond = fz;
         4'hD:    trap_cond = !fz;
         4'hE:    trap_cond = fv;
         4'hF:    trap_cond = 1'b1;
         default: trap_cond = 1'b0;
      endcase
   end

   wire        op_trap   = op_valid_i && (op_i == OP_TRAP);
   wire        is_branch = op_trap && (trap_op_i == 2'b00);
   wire        trap_hit  = op_trap && (trap_code >= `TRAP_MIN_CODE) && trap_cond;
   // Six address bits cover all 64 entries
   wire [31:0] trap_pc   = {`TRAP_HI_ONES, adr_byte_i[7:2], 2'b00};
   wire [4:0]  fl_eff    = (fl == 4'h0) ? `TRAP_FL_ZERO : {1'b0, fl};
   wire [5:0]  save_idx0 = fp_lo + {1'b0, fl_eff};
   wire [5:0]  save_idx1 = save_idx0 + 6'h01;
   wire [31:0] ret_word  = {next_pc_i[31:1], sr_q[`SR_S]};
   wire [31:0] sr_saved  = {sr_q[31:21], `TRAP_ILC, sr_q[18:0]};
   wire [6:0]  fp_new    = sr_q[31:25] + {2'b00, fl_eff};

   // ============================================================
   // Destination write decode
   logic        wr_en;
   logic        wr_loc;
   logic [3:0]  wr_code;
   logic [31:0] wr_data;

   always_comb begin
      wr_en   = 1'b0;
      wr_loc  = dst_local_i;
      wr_code = dst_code_i;
      wr_data = alu_sum;
      sr_d    = sr_q;
      if (op_valid_i) begin
         case (op_i)
            OP_ST_POSTINC: begin
               wr_en   = 1'b1;
               wr_loc  = 1'b1;
               wr_data = ld_val + `ST_WORD_STEP;
            end
            OP_ST_STACKADDR: begin
               wr_en   = 1'b1;
               wr_data = dst_val + dis;
            end
            OP_SUB, OP_SUB_BORROW, OP_SUB_CHECKED: begin
               wr_en          = 1'b1;
               sr_d[`SR_C]    = alu_c;
            end
            OP_SUM, OP_SUM_CHECKED: begin
               wr_en = 1'b1;
            end
            OP_LZC: begin
               wr_en   = 1'b1;
               wr_loc  = 1'b1;
               wr_data = {26'h000_0000, lz_count};
            end
            OP_TRAP: begin
               if (trap_hit) begin
                  sr_d[`SR_FP_LSB +: 7] = fp_new;
                  sr_d[`SR_FL_LSB +: 4] = `TRAP_FL_NEW;
                  sr_d[`SR_M]           = 1'b0;
                  sr_d[`SR_T]           = 1'b0;
                  sr_d[`SR_L]           = 1'b1;
                  sr_d[`SR_S]           = 1'b1;
               end
            end
            default: wr_en = 1'b0;
         endcase
         if (is_sub || is_sum) begin
            sr_d[`SR_Z] = alu_z;
            sr_d[`SR_N] = alu_n;
            sr_d[`SR_V] = alu_v;
         end
      end
   end

   // Flags outrank a result that names the status word as destination
   wire wr_glob = wr_en && !wr_loc && (wr_code > `REG_SR);
   wire wr_locl = wr_en && wr_loc;

   // ============================================================
   // Register file
   always_ff @(posedge clk_i) begin
      if (op_valid_i) begin
         if (wr_glob)
            glob_q[wr_code] <= wr_data;
         if (wr_locl)
            loc_q[dst_idx] <= wr_data;
         if (trap_hit) begin
            loc_q[save_idx0] <= ret_word;
            loc_q[save_idx1] <= sr_saved;
         end
      end else if (load_valid_i) begin
         if (load_local_i)
            loc_q[fp_lo + {2'b00, load_code_i}] <= load_data_i;
         else if (load_code_i > `REG_SR)
            glob_q[load_code_i] <= load_data_i;
      end
   end

   wire load_pc = !op_valid_i && load_valid_i && !load_local_i && (load_code_i == `REG_PC);
   wire load_sr = !op_valid_i && load_valid_i && !load_local_i && (load_code_i == `REG_SR);

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         pc_q <= 32'h0000_0000;
         sr_q <= `SR_RESET;
      end else begin
         if (trap_hit)
            pc_q <= trap_pc;
         else if (op_valid_i)
            pc_q <= next_pc_i;
         else if (load_pc)
            pc_q <= load_data_i;
         if (op_valid_i)
            sr_q <= sr_d;
         else if (load_sr)
            sr_q <= load_data_i;
      end
   end

   // ============================================================
   // Store port and status pulses
   wire is_store = op_valid_i && ((op_i == OP_ST_POSTINC) || (op_i == OP_ST_REGADDR) ||
                                  (op_i == OP_ST_STACKADDR));
   wire [31:0] st_addr = (op_i == OP_ST_STACKADDR) ? dst_val : ld_val;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         mem_we_q    <= 1'b0;
         mem_addr_q  <= 32'h0000_0000;
         mem_wdata_q <= 32'h0000_0000;
         done_q      <= 1'b0;
         range_q     <= 1'b0;
         trap_q      <= 1'b0;
         branch_q    <= 1'b0;
         obs_q       <= 32'h0000_0000;
         ld_idx_q    <= 6'h00;
      end else begin
         mem_we_q    <= is_store;
         mem_addr_q  <= st_addr;
         mem_wdata_q <= src_val;
         done_q      <= op_valid_i;
         range_q     <= op_valid_i && is_check && alu_v;
         trap_q      <= trap_hit;
         branch_q    <= is_branch;
         obs_q       <= rd_reg(obs_local_i, obs_code_i);
         ld_idx_q    <= dst_idx;
      end
   end

   assign obs_data_o    = obs_q;
   assign pc_o          = pc_q;
   assign sr_o          = sr_q;
   assign mem_we_o      = mem_we_q;
   assign mem_addr_o    = mem_addr_q;
   assign mem_wdata_o   = mem_wdata_q;
   assign done_o        = done_q;
   assign range_error_o = range_q;
   assign trap_taken_o  = trap_q;
   assign branch_op_o   = branch_q;

   // ============================================================
   // Assertions
   sequence s_trap_req;
      op_valid_i && (op_i == OP_TRAP) && trap_hit;
   endsequence

   sequence s_postinc_req;
      op_valid_i && (op_i == OP_ST_POSTINC);
   endsequence

   a_postinc_store:
   assert property (@(posedge clk_i) disable iff (reset_i)
      s_postinc_req |=> mem_we_o && (mem_addr_o == $past(ld_val))
                        && (loc_q[ld_idx_q] == $past(ld_val) + `ST_WORD_STEP))
      else $error("post-increment store address or bump wrong");

   a_regaddr_store:
   assert property (@(posedge clk_i) disable iff (reset_i)
      op_valid_i && (op_i == OP_ST_REGADDR) |=> mem_we_o
         && (mem_addr_o == $past(ld_val)) && (loc_q[ld_idx_q] == $past(ld_val)))
      else $error("register-address store changed its address");

   a_stack_store:
   assert property (@(posedge clk_i) disable iff (reset_i)
      op_valid_i && (op_i == OP_ST_STACKADDR) |=> mem_we_o
         && (mem_addr_o == $past(dst_val)) && (mem_wdata_o == $past(src_val)))
      else $error("stack store address or data wrong");

   a_range_error:
   assert property (@(posedge clk_i) disable iff (reset_i)
      op_valid_i && is_check |=> (range_error_o == $past(alu_v)) && done_o)
      else $error("range error does not follow signed overflow");

   a_lzc_flags_kept:
   assert property (@(posedge clk_i) disable iff (reset_i)
      op_valid_i && (op_i == OP_LZC) |=> (sr_o == $past(sr_o)))
      else $error("leading zero count changed the status word");

   a_trap_entry:
   assert property (@(posedge clk_i) disable iff (reset_i)
      s_trap_req |=> trap_taken_o && sr_o[`SR_S]
         && (pc_o == {`TRAP_HI_ONES, $past(adr_byte_i[7:2]), 2'b00}))
      else $error("trap entry address or supervisor flag wrong");

   a_trap_frame:
   assert property (@(posedge clk_i) disable iff (reset_i)
      s_trap_req |=> (sr_o[`SR_FL_LSB +: 4] == `TRAP_FL_NEW) && !sr_o[`SR_M]
         && !sr_o[`SR_T] && sr_o[`SR_L] && (sr_o[3:0] == $past(sr_o[3:0])))
      else $error("new trap frame state wrong");

   a_no_trap_seq:
   assert property (@(posedge clk_i) disable iff (reset_i)
      op_valid_i && (op_i == OP_TRAP) && !trap_hit |=> !trap_taken_o
         && (pc_o == $past(next_pc_i)) && (sr_o == $past(sr_o)))
      else $error("untaken trap did not continue sequentially");

   a_branch_codes:
   assert property (@(posedge clk_i) disable iff (reset_i)
      op_valid_i && (op_i == OP_TRAP) && (trap_op_i == 2'b00) |=> branch_op_o && !trap_taken_o)
      else $error("codes 0..3 must not trap");
endmodule

// [hw/core_exec_regs.svh]
// Field positions, widths and constants of the store, arithmetic and trap execution slice
`ifndef CORE_EXEC_REGS_SVH
`define CORE_EXEC_REGS_SVH

// ============================================================
// Status word layout
`define SR_C         0
`define SR_Z         1
`define SR_N         2
`define SR_V         3
`define SR_M         4
`define SR_T         8
`define SR_L         15
`define SR_S         18
`define SR_ILC_LSB   19
`define SR_FL_LSB    21
`define SR_FP_LSB    25
`define SR_RESET     32'h0000_0000

// ============================================================
// Register numbers and constants
`define REG_PC       4'h0
`define REG_SR       4'h1
`define ST_WORD_STEP 32'h0000_0004
`define TRAP_FL_NEW  4'h6
`define TRAP_FL_ZERO 5'h10
`define TRAP_ILC     2'h1
`define TRAP_HI_ONES 24'hFF_FFFF
`define TRAP_MIN_CODE 4'h4

`endif

// [hw/core_exec_pkg.sv]
// Types shared by the execution slice and its bench
package core_exec_pkg;
   typedef enum logic [3:0] {
      OP_NONE         = 4'h0,
      OP_ST_POSTINC   = 4'h1,
      OP_ST_REGADDR   = 4'h2,
      OP_ST_STACKADDR = 4'h3,
      OP_SUB          = 4'h4,
      OP_SUB_BORROW   = 4'h5,
      OP_SUB_CHECKED  = 4'h6,
      OP_SUM          = 4'h7,
      OP_SUM_CHECKED  = 4'h8,
      OP_LZC          = 4'h9,
      OP_TRAP         = 4'hA
   } op_t;
endpackage

// [hw/add_flags_unit.sv]
// 32-bit adder/subtractor with zero, negative, overflow and carry/borrow flags
`timescale 1ns/1ps
module add_flags_unit (
   input  wire logic [31:0] a_i,
   input  wire logic [31:0] b_i,
   input  wire logic        sub_i,
   input  wire logic        cin_i,
   output logic      [31:0] sum_o,
   output logic             z_o,
   output logic             n_o,
   output logic             v_o,
   output logic             c_o
);
   wire [32:0] full_add = {1'b0, a_i} + {1'b0, b_i} + {32'h0000_0000, cin_i};
   wire [32:0] full_sub = {1'b0, a_i} - {1'b0, b_i} - {32'h0000_0000, cin_i};
   wire [32:0] full     = sub_i ? full_sub : full_add;
   wire        b_eff    = sub_i ? ~b_i[31] : b_i[31];

   assign sum_o = full[31:0];
   assign z_o   = (full[31:0] == 32'h0000_0000);
   assign n_o   = full[31];
   // Carry reads as borrow when subtracting
   assign c_o   = full[32];
   assign v_o   = (a_i[31] == b_eff) && (full[31] != a_i[31]);
endmodule

// [hw/lead_zero_count.sv]
// Leading zero counter, 32 for an all-zero word
`timescale 1ns/1ps
module lead_zero_count (
   input  wire logic [31:0] value_i,
   output logic      [5:0]  count_o
);
   always_comb begin
      logic found;
      found   = 1'b0;
      count_o = 6'h20;
      for (int i = 31; i >= 0; i--) begin
         if (!found && value_i[i]) begin
            found   = 1'b1;
            count_o = 6'(31 - i);
         end
      end
   end
endmodule

// [dv/word_store_memory.sv]
// Data memory model that takes the word stores of the execution slice
`timescale 1ns/1ps
module word_store_memory (
   input  wire logic        clk_i,
   input  wire logic        we_i,
   input  wire logic [31:0] addr_i,
   input  wire logic [31:0] wdata_i,
   output logic      [31:0] stores_o
);
   // Stores are posted: the slice has no ready, so this memory can never stall it
   logic [31:0] mem [logic [31:0]];
   initial stores_o = 32'h0;
   always @(posedge clk_i) begin
      if (we_i === 1'b1) begin
         mem[addr_i] = wdata_i;
         stores_o <= stores_o + 32'h1;
      end
   end
endmodule

// [dv/store_arith_trap_exec_tb.sv]
// Self-checking bench for the store, arithmetic and trap execution slice
`timescale 1ns/1ps
module store_arith_trap_exec_tb;
   import core_exec_pkg::*;
   typedef logic [7:0][31:0] exp_t;
   // INSTR_LENGTH_CODE of the live status word is left to the design, so it is not compared
   localparam logic [31:0] ILC_MASK = 32'hFFE7_FFFF;
   logic        clk_i, reset_i, op_valid_i, src_local_i, dst_local_i, imm_sign_i, imm_ext_i;
   logic        load_valid_i, load_local_i, obs_local_i;
   logic        mem_we_o, done_o, range_error_o, trap_taken_o, branch_op_o;
   logic [3:0]  src_code_i, dst_code_i, load_code_i, obs_code_i, c;
   logic [13:0] imm1_i;
   logic [15:0] imm2_i;
   logic [1:0]  trap_op_i;
   logic [7:0]  adr_byte_i;
   logic [31:0] next_pc_i, load_data_i, obs_data_o, pc_o, sr_o, mem_addr_o, mem_wdata_o;
   logic [31:0] stores, r, sr, pc;
   logic [31:0] lfsr_q = 32'h43BB_492B;
   logic [31:0] loc [64];
   logic [31:0] glb [16];
   op_t         op_i, so;
   exp_t        got;
   exp_t        q [$];
   int          miscompares = 0;
   int          checked = 0;
   int          nstores = 0;

   store_arith_trap_exec i_dut (
      .clk_i(clk_i), .reset_i(reset_i), .op_valid_i(op_valid_i), .op_i(op_i),
      .src_local_i(src_local_i), .src_code_i(src_code_i), .dst_local_i(dst_local_i),
      .dst_code_i(dst_code_i), .imm_sign_i(imm_sign_i), .imm_ext_i(imm_ext_i),
      .imm1_i(imm1_i), .imm2_i(imm2_i), .trap_op_i(trap_op_i), .adr_byte_i(adr_byte_i),
      .next_pc_i(next_pc_i), .load_valid_i(load_valid_i), .load_local_i(load_local_i),
      .load_code_i(load_code_i), .load_data_i(load_data_i), .obs_local_i(obs_local_i),
      .obs_code_i(obs_code_i), .obs_data_o(obs_data_o), .pc_o(pc_o), .sr_o(sr_o),
      .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
      .done_o(done_o), .range_error_o(range_error_o), .trap_taken_o(trap_taken_o),
      .branch_op_o(branch_op_o));
   word_store_memory i_mem (.clk_i(clk_i), .we_i(mem_we_o), .addr_i(mem_addr_o),
      .wdata_i(mem_wdata_o), .stores_o(stores));

   // ============================================================
   // Helpers
   function automatic logic [31:0] rnd();
      lfsr_q = {lfsr_q[30:0], 1'b0} ^ (lfsr_q[31] ? 32'h0040_0007 : 32'h0);
      return lfsr_q;
   endfunction
   function automatic logic [31:0] rd(input logic l, input logic [3:0] k);
      if (l) return loc[6'(sr[30:25] + 6'(k))];
      if (k == 4'h0) return pc;
      if (k == 4'h1) return sr;
      return glb[k];
   endfunction
   task automatic wr(input logic l, input logic [3:0] k, input logic [31:0] v);
      if (l) loc[6'(sr[30:25] + 6'(k))] = v;
      else if (k > 4'h1) glb[k] = v;
   endtask
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
      checked++;
      if (s !== x) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, x, s);
      end
   endtask
   task automatic test_done();
      if (miscompares == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic load(input logic l, input logic [3:0] k, input logic [31:0] v);
      @(negedge clk_i);
      op_valid_i = 1'b0;
      {load_valid_i, load_local_i, load_code_i, load_data_i} = {1'b1, l, k, v};
      if (!l && k == 4'h0) pc = v;
      else if (!l && k == 4'h1) sr = v;
      else wr(l, k, v);
   endtask
   task automatic rdreg(input logic l, input logic [3:0] k);
      @(negedge clk_i);
      {op_valid_i, load_valid_i, obs_local_i, obs_code_i} = {2'b00, l, k};
      @(negedge clk_i);
      chk("reg", obs_data_o, rd(l, k));
   endtask
   task automatic chk_regs();
      for (int k = 0; k < 32; k++) if (k != 1) rdreg(k[4], k[3:0]);
   endtask

   // ============================================================
   // Driver: issues one instruction and notes what must come out
   task automatic exec(input op_t op, input logic sl, input logic [3:0] sc, input logic dl,
                       input logic [3:0] dc, input logic [31:0] f, input logic [9:0] t);
      logic [31:0] a, b, w0, dis, cst, np;
      logic [32:0] w;
      logic [6:0]  fl;
      logic        tk, cin;
      exp_t        x;
      @(negedge clk_i);
      np = rnd();
      {load_valid_i, op_valid_i, next_pc_i} = {2'b01, np};
      op_i = op;
      {src_local_i, src_code_i, dst_local_i, dst_code_i} = {sl, sc, dl, dc};
      {imm_sign_i, imm_ext_i, imm1_i, imm2_i} = f;
      {trap_op_i, adr_byte_i} = t;
      a = rd(dl, dc);
      b = (!sl && sc == 4'h1) ? {31'h0, sr[0]} : rd(sl, sc);
      dis = f[30] ? {{4{f[31]}}, f[27:0]} : {{20{f[31]}}, f[27:16]};
      cst = f[30] ? {{2{f[31]}}, f[29:0]} : {{18{f[31]}}, f[29:16]};
      cin = (op == OP_SUB_BORROW) & sr[0];
      x = '0;
      x[6] = np;
      case (op)
         OP_ST_POSTINC, OP_ST_REGADDR, OP_ST_STACKADDR: begin
            {x[0], x[1], x[2]} = {32'h1, a, b};
            nstores++;
            if (op == OP_ST_POSTINC) wr(dl, dc, a + 32'h4);
            if (op == OP_ST_STACKADDR) wr(dl, dc, a + dis);
         end
         OP_SUB, OP_SUB_BORROW, OP_SUB_CHECKED, OP_SUM, OP_SUM_CHECKED: begin
            if (op >= OP_SUM) w = {b[31], b} + {cst[31], cst};
            else begin
               w = {a[31], a} - {b[31], b} - 33'(cin);
               sr[0] = {1'b0, a} < {1'b0, b} + 33'(cin);
            end
            w0 = w[31:0];
            sr[3:1] = {w[32] ^ w[31], w0[31], w0 == 32'h0};
            x[3] = 32'((op == OP_SUB_CHECKED || op == OP_SUM_CHECKED) && sr[3]);
            wr(dl, dc, w0);
         end
         OP_LZC: begin
            w0 = 32'd32;
            for (int i = 0; i < 32; i++) if (b[i]) w0 = 32'(31 - i);
            wr(1'b1, dc, w0);
         end
         OP_TRAP: begin
            case ({t[9:8], t[1]})
               3'd2: tk = (sr[2] | sr[1]) ^ t[0];
               3'd3: tk = sr[2] ^ t[0];
               3'd4: tk = (sr[0] | sr[1]) ^ t[0];
               3'd5: tk = sr[0] ^ t[0];
               3'd6: tk = sr[1] ^ t[0];
               3'd7: tk = sr[3] | t[0];
               default: tk = 1'b0;
            endcase
            x[4] = 32'(tk);
            x[5] = 32'(t[9:8] == 2'b00);
            if (tk) begin
               fl = (sr[24:21] == 4'h0) ? 7'd16 : 7'(sr[24:21]);
               loc[6'(sr[30:25] + fl)] = {np[31:1], sr[18]};
               loc[6'(sr[30:25] + fl + 7'd1)] = {sr[31:21], 2'b01, sr[18:0]};
               sr[31:21] = {sr[31:25] + fl, 4'h6};
               {sr[18], sr[15], sr[8], sr[4]} = 4'b1100;
               x[6] = {24'hFF_FFFF, t[7:2], 2'b00};
            end
         end
         default: ;
      endcase
      pc = x[6];
      x[7] = sr;
      q.push_back(x);
   endtask

   // ============================================================
   // Monitor
   always @(negedge clk_i) begin
      if (done_o === 1'b1) begin
         got = (q.size() > 0) ? q.pop_front() : '1;
         chk("store", {31'h0, mem_we_o}, got[0]);
         if (got[0] == 32'h1) chk("addr", mem_addr_o, got[1]);
         if (got[0] == 32'h1) chk("wdata", mem_wdata_o, got[2]);
         chk("range", {31'h0, range_error_o}, got[3]);
         chk("trap", {31'h0, trap_taken_o}, got[4]);
         chk("branch", {31'h0, branch_op_o}, got[5]);
         chk("pc", pc_o, got[6]);
         chk("sr", sr_o & ILC_MASK, got[7] & ILC_MASK);
      end
   end

   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   initial begin
      #100000;
      miscompares++;
      test_done();
   end

   // ============================================================
   // Scenarios
   initial begin
      {reset_i, op_valid_i, load_valid_i, src_local_i, dst_local_i, imm_sign_i} = 6'b100000;
      {imm_ext_i, load_local_i, obs_local_i, src_code_i, dst_code_i, load_code_i} = '0;
      {obs_code_i, imm1_i, imm2_i, trap_op_i, adr_byte_i, next_pc_i, load_data_i} = '0;
      op_i = OP_NONE;
      {sr, pc} = '0;
      repeat (16) @(negedge clk_i);
      reset_i = 1'b0;
      chk("reset_pc", pc_o, 32'h0);
      chk("reset_sr", sr_o, 32'h0);
      for (int k = 0; k < 16; k++) load(1'b0, 4'(k), rnd());
      rdreg(1'b0, 4'h0);
      for (int k = 0; k < 64; k++) begin
         if (k % 16 == 0) load(1'b0, 4'h1, {7'(k), 25'h0});
         load(1'b1, 4'(k), rnd());
      end
      load(1'b0, 4'h1, 32'h0);
      exec(OP_ST_POSTINC, 1'b0, 4'h5, 1'b1, 4'h3, 32'h0, 10'h0);
      exec(OP_ST_POSTINC, 1'b1, 4'h3, 1'b1, 4'h3, 32'h0, 10'h0);
      exec(OP_ST_REGADDR, 1'b0, 4'h5, 1'b1, 4'h3, 32'h0, 10'h0);
      exec(OP_ST_STACKADDR, 1'b1, 4'h2, 1'b1, 4'h4, 32'h8000_0000, 10'h0);
      exec(OP_ST_STACKADDR, 1'b0, 4'h6, 1'b0, 4'h7, 32'h4FFF_FFFF, 10'h0);
      for (int k = 0; k < 8; k++) begin
         r = rnd();
         so = op_t'(4'h1 + {2'b00, r[1:0] % 2'd3});
         exec(so, r[2], r[7:4] | 4'h2, r[3] | (so != OP_ST_STACKADDR), r[11:8] | 4'h2,
              rnd(), 10'h0);
      end
      chk_regs();
      load(1'b1, 4'h0, 32'h8000_0000);
      load(1'b1, 4'h1, 32'h1);
      load(1'b1, 4'h2, 32'h7FFF_FFFF);
      exec(OP_SUB_CHECKED, 1'b1, 4'h1, 1'b1, 4'h0, 32'h0, 10'h0);
      exec(OP_SUM_CHECKED, 1'b1, 4'h2, 1'b1, 4'h3, 32'h0001_0000, 10'h0);
      exec(OP_SUM, 1'b1, 4'h2, 1'b1, 4'h4, 32'h8000_0000, 10'h0);
      exec(OP_SUB, 1'b1, 4'h1, 1'b1, 4'h1, 32'h0, 10'h0);
      for (int o = 4; o < 9; o++) begin
         load(1'b0, 4'h1, {28'h0, 4'(o)});
         exec(op_t'(o), 1'b0, 4'h1, 1'b1, 4'h5, rnd(), 10'h0);
      end
      for (int k = 0; k < 40; k++) begin
         r = rnd();
         exec(op_t'(4'h4 + {1'b0, r[2:0] % 3'd5}), r[3],
              (r[3] || r[7:4] != 4'h0) ? r[7:4] : 4'h1, r[8],
              r[12:9] | {2'b00, ~r[8], 1'b0}, rnd(), 10'h0);
      end
      load(1'b1, 4'h6, 32'h0);
      exec(OP_LZC, 1'b1, 4'h6, 1'b1, 4'h7, 32'h0, 10'h0);
      for (int k = 0; k < 6; k++) begin
         r = rnd();
         load(1'b1, 4'h6, rnd() >> r[4:0]);
         exec(OP_LZC, 1'b1, 4'h6, 1'b1, 4'(k), 32'h0, 10'h0);
      end
      chk_regs();
      for (int k = 0; k < 48; k++) begin
         r = rnd();
         c = 4'(k);
         load(1'b0, 4'h1, {sr[31:25], r[7:4], 2'b00, r[8], 14'h0, r[3:0]});
         exec(OP_TRAP, 1'b0, 4'h0, 1'b0, 4'h0, 32'h0, {c[3:2], r[15:10], c[1:0]});
         rdreg(1'b1, 4'h0);
         rdreg(1'b1, 4'h1);
      end
      chk("stores", stores, 32'(nstores));
      chk("pending", 32'(q.size()), 32'h0);
      test_done();
   end
endmodule
